// ---- hw/fac_capture_ctrl.sv ----
// Capture controller: sample-rate buckets, circular address, post-trigger count, video trigger, APB registers.
`include "fac_defs.svh"

module fac_capture_ctrl #(
    parameter int ADDR_W = 15,
    parameter int DEPTH = 32768
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_clk_in,
    input wire logic [7:0] converter_data,
    input wire logic sweep_strobe,
    output logic video_trig_pulse,
    output logic capture_stop_n,
    output logic post_count_en_n,
    output logic sample_latch_strobe,
    output logic above_level,
    output logic below_level
);

    // ------------------------------------------------------------
    // State and sample memory.
    // ------------------------------------------------------------
    fac_pkg::fac_state_t s_r;
    fac_pkg::fac_state_t s_nxt;
    logic [7:0] mem [DEPTH];
    logic mem_we;
    logic [7:0] mem_wd;
    logic tick;
    logic first;
    logic last;
    logic wr_mode;
    logic rd_mode;
    logic trig_fire;
    logic src_event;
    logic vid_rise;
    logic vid_fall;
    logic acc;
    logic data_wr;
    logic data_rd;
    logic rd_incr;
    logic [7:0] latch_new;
    logic take;

    // ------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        mem_we = 1'b0;
        mem_wd = s_r.latch;
        take = 1'b0;
        latch_new = s_r.latch;
        trig_fire = 1'b0;
        rd_incr = 1'b0;

        s_nxt.smp_s1 = sample_clk_in;
        s_nxt.smp_s2 = s_r.smp_s1;
        s_nxt.smp_s3 = s_r.smp_s2;
        s_nxt.swp_s1 = sweep_strobe;
        s_nxt.swp_s2 = s_r.swp_s1;
        s_nxt.swp_s3 = s_r.swp_s2;
        s_nxt.adc_s1 = converter_data;
        s_nxt.adc_s2 = s_r.adc_s1;

        wr_mode = s_r.ctrl[`FAC_B_WRITE];
        rd_mode = !s_r.ctrl[`FAC_B_WRITE];
        tick = s_r.smp_s2 && !s_r.smp_s3;
        first = s_r.bucket_cnt == `FAC_RATE_RST;
        last = s_r.bucket_cnt == s_r.rate;

        // Bucket counter sets samples per bucket from one to 256.
        if (tick) begin
            s_nxt.bucket_cnt = last ? `FAC_RATE_RST : s_r.bucket_cnt + 1'b1;
        end

        // Sample latch: peak, pit or plain sample detection within a bucket.
        if (tick) begin
            if (first) begin
                take = 1'b1;
            end else if (s_r.ctrl[`FAC_B_SMP]) begin
                if (s_r.ctrl[`FAC_B_PEAK]) begin
                    take = s_r.adc_s2 < s_r.latch;
                end else begin
                    take = s_r.adc_s2 > s_r.latch;
                end
            end
        end
        if (take) begin
            latch_new = s_r.adc_s2;
        end
        s_nxt.latch = latch_new;
        s_nxt.strobe = take;

        // Comparator against the programmed video level.
        if (tick) begin
            s_nxt.above = s_r.adc_s2 > s_r.level;
            s_nxt.below = s_r.adc_s2 < s_r.level;
        end
        vid_rise = s_nxt.above && !s_r.above;
        vid_fall = s_nxt.below && !s_r.below;
        s_nxt.vpulse = !s_r.ctrl[`FAC_B_VEN] && (s_r.ctrl[`FAC_B_POL] ? vid_fall : vid_rise);

        // Trigger source and arming.
        if (!s_r.ctrl[`FAC_B_VEN]) begin
            src_event = s_r.vpulse;
        end else begin
            src_event = s_r.swp_s2 && !s_r.swp_s3;
        end
        if (!s_r.ctrl[`FAC_B_ARM]) begin
            s_nxt.trig_done = 1'b0;
        end else if (wr_mode && src_event && !s_r.trig_done) begin
            trig_fire = 1'b1;
            s_nxt.trig_done = 1'b1;
            s_nxt.trig_addr = s_r.addr;
            s_nxt.count_en_n = 1'b0;
        end

        // Bucket end is the address and post clock in write mode.
        if (wr_mode && tick && last) begin
            mem_we = !s_r.ctrl[`FAC_B_WEN];
            mem_wd = latch_new;
            if (s_r.stop_n) begin
                s_nxt.addr = s_r.addr + 1'b1;
                if (!s_r.count_en_n) begin
                    s_nxt.post = s_r.post + 1'b1;
                end
            end
        end

        // APB slave: no wait states, answer on the first access cycle.
        acc = psel && penable && s_r.pready;
        data_wr = acc && pwrite && paddr == `FAC_OFS_DATA;
        data_rd = acc && !pwrite && paddr == `FAC_OFS_DATA;
        s_nxt.pready = psel && !penable && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h0000_0000;
        if (psel && !penable) begin
            if (paddr == `FAC_OFS_CTRL) begin
                s_nxt.prdata[15:0] = s_r.ctrl;
            end else if (paddr == `FAC_OFS_RATE) begin
                s_nxt.prdata[7:0] = s_r.rate;
            end else if (paddr == `FAC_OFS_DATA) begin
                s_nxt.prdata[7:0] = mem[s_r.addr];
            end else if (paddr == `FAC_OFS_TRIG) begin
                s_nxt.prdata[14:0] = s_r.trig_addr;
            end else if (paddr == `FAC_OFS_STAT) begin
                s_nxt.prdata[`FAC_ST_STOP] = s_r.stop_n;
                s_nxt.prdata[`FAC_ST_TRIG] = s_r.trig_done;
                s_nxt.prdata[`FAC_ST_CNT] = !s_r.count_en_n;
                s_nxt.prdata[`FAC_ST_ABOVE] = s_r.above;
                s_nxt.prdata[`FAC_ST_BELOW] = s_r.below;
                s_nxt.prdata[`FAC_ST_LVL_LO +: 8] = s_r.level;
                s_nxt.prdata[`FAC_ST_ADDR_LO +: 15] = s_r.addr;
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end
        if (acc && pwrite) begin
            if (paddr == `FAC_OFS_CTRL) begin
                s_nxt.ctrl = pwdata[15:0];
            end else if (paddr == `FAC_OFS_RATE) begin
                s_nxt.rate = pwdata[7:0];
                s_nxt.bucket_cnt = `FAC_RATE_RST;
            end
        end

        // Read-mode loads through the data address.
        if (data_wr && rd_mode && !s_r.ctrl[`FAC_B_RCK]) begin
            if (!s_r.ctrl[`FAC_B_PLD]) begin
                s_nxt.post = pwdata[15:0];
            end
            if (!s_r.ctrl[`FAC_B_ALD]) begin
                s_nxt.addr = pwdata[14:0];
            end
        end
        if (data_wr && rd_mode && !s_r.ctrl[`FAC_B_LVL]) begin
            s_nxt.level[`FAC_LVL_HI:`FAC_LVL_LO] = pwdata[`FAC_LVL_HI:`FAC_LVL_LO];
            s_nxt.level[`FAC_LVL_LO-1:0] = '0;
        end

        // Memory read post-increment, gated by stop.
        if (data_rd && rd_mode && !s_r.ctrl[`FAC_B_RCK] && !s_r.ctrl[`FAC_B_RMEM] && s_r.stop_n) begin
            rd_incr = 1'b1;
            s_nxt.addr = s_r.addr + 1'b1;
        end

        // Terminal count stops counting and drops the count enable.
        s_nxt.stop_n = s_nxt.post != `FAC_POST_TC;
        if (!s_nxt.stop_n) begin
            s_nxt.count_en_n = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl <= `FAC_CTRL_RST;
            s_r.rate <= `FAC_RATE_RST;
            s_r.count_en_n <= 1'b1;
            s_r.stop_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[s_r.addr] <= mem_wd;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign video_trig_pulse = s_r.vpulse;
    assign capture_stop_n = s_r.stop_n;
    assign post_count_en_n = s_r.count_en_n;
    assign sample_latch_strobe = s_r.strobe;
    assign above_level = s_r.above;
    assign below_level = s_r.below;

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_done_s;
        psel && penable && pready;
    endsequence

    apb_answer_a: assert property (apb_setup_s |=> apb_done_s or !psel)
        else $error("APB access not answered one cycle after setup.");

    stop_halts_count_a: assert property (!capture_stop_n |-> post_count_en_n)
        else $error("Count enable active while stop is low.");

    stop_tc_a: assert property (capture_stop_n == (s_r.post != `FAC_POST_TC))
        else $error("Stop does not match terminal count.");

    trig_capture_a: assert property (trig_fire |=> s_r.trig_addr == $past(s_r.addr)
        && (!post_count_en_n || !capture_stop_n))
        else $error("Trigger did not latch address or start counting.");

    arm_gate_a: assert property (trig_fire |-> s_r.ctrl[`FAC_B_ARM] && !s_r.trig_done)
        else $error("Trigger taken while disarmed or already used.");

    addr_wrap_a: assert property (wr_mode && tick && last && capture_stop_n && s_r.addr == `FAC_ADDR_TOP
        && !(psel && penable) |=> s_r.addr == '0)
        else $error("Address counter failed to wrap.");

    cmp_above_a: assert property (tick |=> above_level == ($past(s_r.adc_s2) > $past(s_r.level)))
        else $error("Above-level output wrong.");

    cmp_below_a: assert property (tick |=> below_level == ($past(s_r.adc_s2) < $past(s_r.level)))
        else $error("Below-level output wrong.");

    post_load_a: assert property (data_wr && rd_mode && !s_r.ctrl[`FAC_B_RCK] && !s_r.ctrl[`FAC_B_PLD]
        |=> s_r.post == $past(pwdata[15:0]))
        else $error("Post counter not loaded from data write.");

    addr_load_a: assert property (data_wr && rd_mode && !s_r.ctrl[`FAC_B_RCK] && !s_r.ctrl[`FAC_B_ALD]
        |=> s_r.addr == $past(pwdata[14:0]))
        else $error("Address counter not loaded from data write.");

    read_incr_a: assert property (rd_incr |=> s_r.addr == $past(s_r.addr) + 15'h0001)
        else $error("Memory read did not post-increment.");

    read_hold_a: assert property (data_rd && !capture_stop_n |=> $stable(s_r.addr))
        else $error("Address moved while stop low.");

    bucket_first_a: assert property (tick && first |=> sample_latch_strobe && s_r.latch == $past(s_r.adc_s2))
        else $error("First sample of bucket not forced into latch.");

    vid_pol_a: assert property (video_trig_pulse |-> !$past(s_r.ctrl[`FAC_B_VEN]) &&
        ($past(s_r.ctrl[`FAC_B_POL]) ? $rose(below_level) : $rose(above_level)))
        else $error("Video trigger edge does not match polarity.");

    sequence store_step_s;
        wr_mode && tick && last && capture_stop_n;
    endsequence

    sequence peak_step_s;
        tick && !first && s_r.ctrl[`FAC_B_SMP] && !s_r.ctrl[`FAC_B_PEAK];
    endsequence

    sequence pit_step_s;
        tick && !first && s_r.ctrl[`FAC_B_SMP] && s_r.ctrl[`FAC_B_PEAK];
    endsequence

    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("Slave error raised without ready.");

    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("Read data not zero outside the access cycle.");

    disarm_clear_a: assert property (!s_r.ctrl[`FAC_B_ARM] |=> !s_r.trig_done)
        else $error("Trigger flag not cleared while disarmed.");

    write_advance_a: assert property (store_step_s |=> s_r.addr == $past(s_r.addr) + 15'h0001)
        else $error("Address did not advance on a stored sample.");

    post_count_a: assert property (store_step_s ##0 !post_count_en_n
        |=> s_r.post == $past(s_r.post) + 16'h0001)
        else $error("Post counter did not count on a bucket end.");

    post_idle_a: assert property (post_count_en_n && !data_wr |=> $stable(s_r.post))
        else $error("Post counter moved while count enable inactive.");

    stop_freeze_a: assert property (wr_mode && !capture_stop_n |=> $stable(s_r.addr))
        else $error("Address moved in write mode while stop low.");

    vid_off_a: assert property (s_r.ctrl[`FAC_B_VEN] |=> !video_trig_pulse)
        else $error("Video trigger pulse while video trigger disabled.");

    mem_gate_a: assert property (mem_we |-> wr_mode && !s_r.ctrl[`FAC_B_WEN])
        else $error("Memory written while write enable inactive.");

    sweep_src_a: assert property (trig_fire && s_r.ctrl[`FAC_B_VEN] |-> $rose(s_r.swp_s2))
        else $error("Sweep trigger without a sweep strobe edge.");

    video_src_a: assert property (trig_fire && !s_r.ctrl[`FAC_B_VEN] |-> video_trig_pulse)
        else $error("Video trigger without a video pulse.");

    peak_keep_a: assert property (peak_step_s
        |=> s_r.latch >= $past(s_r.adc_s2) && s_r.latch >= $past(s_r.latch))
        else $error("Peak detection did not keep the maximum.");

    pit_keep_a: assert property (pit_step_s
        |=> s_r.latch <= $past(s_r.adc_s2) && s_r.latch <= $past(s_r.latch))
        else $error("Pit detection did not keep the minimum.");

endmodule

// ---- hw/fac_defs.svh ----
// Register offsets, control word fields, reset values and counts of the capture controller.
// Operation
// - Sample-rate tick clocks both the address counter and post-trigger counter.
// - Samples per bucket are programmable from one up to 256.
// - Sample mode low below full rate stores the bucket's first sample.
// - Trigger latches current address and starts the post-trigger counter.
// - After trigger, samples go to consecutive addresses until terminal count.
// - Trigger accepted only while armed; re-arm by dropping and raising arm.
// - Sweep strobe triggers normally; comparator video trigger when video enabled.
// - Read mode data write with post-load and read-clock low loads post counter.
// - Post counter counts up on ticks after its count enable asserts.
// - Terminal count drives stop low, halting address and post counting.
// - Address counter is fifteen bits and wraps from top back to zero.
// - Read mode data write with address-load and read-clock low loads address.
// - Memory read with read-clock low post-increments the address counter.
// - Read post-increment happens only while stop is high.
// - Eight-bit comparator checks each sample against a level loaded in read mode.
// - Above only when sample greater, below only when less, none when equal.
// - Above and below outputs drive the video trigger generator.
// - Polarity bit set selects falling video trigger, clear selects rising.
// - Video trigger enable is active low.
// - Memory write enable is active low.
// - Peak/pit select chooses pit when set, peak when clear, if sample mode high.
`ifndef FAC_DEFS_SVH
`define FAC_DEFS_SVH
`define FAC_OFS_CTRL 12'h000
`define FAC_OFS_RATE 12'h004
`define FAC_OFS_DATA 12'h008
`define FAC_OFS_TRIG 12'h00c
`define FAC_OFS_STAT 12'h010
`define FAC_B_WRITE 0
`define FAC_B_ARM 1
`define FAC_B_POL 3
`define FAC_B_SMP 4
`define FAC_B_WEN 5
`define FAC_B_ALD 6
`define FAC_B_PLD 7
`define FAC_B_VEN 8
`define FAC_B_RCK 9
`define FAC_B_RMEM 10
`define FAC_B_LVL 14
`define FAC_B_PEAK 15
`define FAC_LVL_LO 2
`define FAC_LVL_HI 7
`define FAC_ST_STOP 0
`define FAC_ST_TRIG 1
`define FAC_ST_CNT 2
`define FAC_ST_ABOVE 3
`define FAC_ST_BELOW 4
`define FAC_ST_LVL_LO 8
`define FAC_ST_ADDR_LO 16
`define FAC_CTRL_RST 16'h7ff0
`define FAC_RATE_RST 8'h00
`define FAC_POST_TC 16'hffff
`define FAC_ADDR_TOP 15'h7fff
`endif

// ---- hw/fac_pkg.sv ----
// Package holding the state type of the capture controller.
package fac_pkg;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0] rate;
        logic [7:0] level;
        logic [14:0] addr;
        logic [14:0] trig_addr;
        logic [15:0] post;
        logic count_en_n;
        logic stop_n;
        logic trig_done;
        logic [7:0] bucket_cnt;
        logic [7:0] latch;
        logic above;
        logic below;
        logic vpulse;
        logic strobe;
        logic smp_s1;
        logic smp_s2;
        logic smp_s3;
        logic swp_s1;
        logic swp_s2;
        logic swp_s3;
        logic [7:0] adc_s1;
        logic [7:0] adc_s2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fac_state_t;
endpackage

// ---- test/fac_front_model.sv ----
// Converter front end model: free-running sample clock, sample value and sweep strobe.
module fac_front_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] level,
    input wire logic fire,
    output logic sample_clk_in,
    output logic [7:0] converter_data,
    output logic sweep_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase;
    logic pend;
    logic [3:0] hold;
    // ----------------------------------------
    // Sample clock and sweep timing
    // ----------------------------------------
    // The sample clock is high eight cycles and low eight cycles.
    assign sample_clk_in = phase[3];
    assign converter_data = level;
    // The sweep strobe rises seven cycles before a sample edge and stays high sixteen cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 4'h0;
            pend <= 1'b0;
            hold <= 4'h0;
            sweep_strobe <= 1'b0;
        end else begin
            phase <= phase + 4'h1;
            if (fire) begin
                pend <= 1'b1;
            end
            if (pend && phase == 4'h0) begin
                sweep_strobe <= 1'b1;
                hold <= 4'hf;
                pend <= 1'b0;
            end else if (hold != 4'h0) begin
                hold <= hold - 4'h1;
            end else begin
                sweep_strobe <= 1'b0;
            end
        end
    end
endmodule

// ---- test/tb_fast_adc_capture_control.sv ----
// Testbench of the capture controller: register tasks and capture scenarios.
`include "fac_defs.svh"
module tb_fast_adc_capture_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic fire = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] dval = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, sample_clk_in, sweep_strobe, video_trig_pulse, capture_stop_n;
    logic post_count_en_n, sample_latch_strobe, above_level, below_level, err;
    logic [7:0] converter_data;
    logic [31:0] rdv;
    logic [14:0] t;
    int bad_count = 0;
    int num_checks = 0;
    always #4 pclk = ~pclk;
    fac_capture_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_clk_in(sample_clk_in), .converter_data(converter_data), .sweep_strobe(sweep_strobe),
        .video_trig_pulse(video_trig_pulse), .capture_stop_n(capture_stop_n), .post_count_en_n(post_count_en_n),
        .sample_latch_strobe(sample_latch_strobe), .above_level(above_level), .below_level(below_level));
    fac_front_model model (.pclk(pclk), .presetn(presetn), .level(dval), .fire(fire),
        .sample_clk_in(sample_clk_in), .converter_data(converter_data), .sweep_strobe(sweep_strobe));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            $display("mismatch pready expected 1 seen timeout");
            wrap_up();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdv & m);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return post_count_en_n;
            1: return capture_stop_n;
            2: return video_trig_pulse;
            3: return above_level;
            4: return above_level | below_level;
            6: return sample_latch_strobe;
            default: return below_level;
        endcase
    endfunction
    task automatic waitv(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(s) !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        num_checks++;
        if (n >= lim) begin
            bad_count++;
            $display("mismatch output %0d expected %b seen timeout", s, v);
            wrap_up();
        end
    endtask
    task automatic sweep;
        @(posedge pclk);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
    endtask
    task automatic reload(input logic [31:0] d);
        wr(`FAC_OFS_CTRL, 32'h0000_7d30);
        wr(`FAC_OFS_DATA, d);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("stop_n", 32'h0000_0001, {31'h0, capture_stop_n});
        chk("count_en_n", 32'h0000_0001, {31'h0, post_count_en_n});
        rchk(`FAC_OFS_CTRL, 32'h0000_ffff, 32'h0000_7ff0, "ctrl");
        xfer(1'b0, 12'h020, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0, err});
        wr(`FAC_OFS_RATE, 32'h0000_00ff);
        rchk(`FAC_OFS_RATE, 32'h0000_00ff, 32'h0000_00ff, "rate");
        wr(`FAC_OFS_RATE, 32'h0000_0000);
        $display("test registers done");
        wr(`FAC_OFS_CTRL, 32'h0000_3ff0);
        wr(`FAC_OFS_DATA, 32'h0000_0043);
        rchk(`FAC_OFS_STAT, 32'h0000_ff00, 32'h0000_4000, "level");
        reload(32'h0000_7ffe);
        rchk(`FAC_OFS_STAT, 32'h7fff_0001, 32'h7ffe_0001, "addr load");
        wr(`FAC_OFS_CTRL, 32'h0000_79f0);
        xfer(1'b0, `FAC_OFS_DATA, 32'h0000_0000);
        xfer(1'b0, `FAC_OFS_DATA, 32'h0000_0000);
        rchk(`FAC_OFS_STAT, 32'h7fff_0001, 32'h0000_0001, "addr wrap");
        wr(`FAC_OFS_CTRL, 32'h0000_7d70);
        wr(`FAC_OFS_DATA, 32'h0000_ffff);
        rchk(`FAC_OFS_STAT, 32'h7fff_0001, 32'h0000_0000, "post load");
        wr(`FAC_OFS_CTRL, 32'h0000_79f0);
        xfer(1'b0, `FAC_OFS_DATA, 32'h0000_0000);
        rchk(`FAC_OFS_STAT, 32'h7fff_0001, 32'h0000_0000, "addr held");
        $display("test read mode done");
        wr(`FAC_OFS_RATE, 32'h0000_0001);
        wr(`FAC_OFS_CTRL, 32'h0000_7ff1);
        dval <= 8'h50;
        waitv(3, 1'b1, 200);
        chk("below", 32'h0000_0000, {31'h0, below_level});
        dval <= 8'h30;
        waitv(5, 1'b1, 200);
        chk("above", 32'h0000_0000, {31'h0, above_level});
        dval <= 8'h40;
        waitv(4, 1'b0, 200);
        waitv(6, 1'b1, 40);
        wr(`FAC_OFS_RATE, 32'h0000_0000);
        $display("test comparator done");
        reload(32'h0000_fff0);
        wr(`FAC_OFS_CTRL, 32'h0000_7ff1);
        sweep();
        repeat (40) @(posedge pclk);
        chk("disarmed", 32'h0000_0001, {31'h0, post_count_en_n});
        wr(`FAC_OFS_CTRL, 32'h0000_7fd3);
        sweep();
        waitv(0, 1'b0, 60);
        waitv(1, 1'b0, 600);
        chk("count stop", 32'h0000_0001, {31'h0, post_count_en_n});
        sweep();
        repeat (40) @(posedge pclk);
        wr(`FAC_OFS_CTRL, 32'h0000_7ff0);
        xfer(1'b0, `FAC_OFS_TRIG, 32'h0000_0000);
        t = rdv[14:0];
        rchk(`FAC_OFS_STAT, 32'h7fff_0005, {1'b0, t + 15'h000f, 16'h0000}, "post span");
        reload({17'h0_0000, t});
        wr(`FAC_OFS_CTRL, 32'h0000_79f0);
        rchk(`FAC_OFS_DATA, 32'h0000_00ff, 32'h0000_0040, "sample");
        rchk(`FAC_OFS_STAT, 32'h7fff_0001, {1'b0, t + 15'h0001, 16'h0001}, "read incr");
        $display("test capture done");
        for (int p = 0; p < 2; p++) begin
            reload(32'h0000_fff0);
            dval <= (p == 1) ? 8'h50 : 8'h30;
            wr(`FAC_OFS_CTRL, 32'h0000_7ed3 | 32'(p << 3));
            repeat (48) @(posedge pclk);
            chk("no video", 32'h0000_0001, {31'h0, post_count_en_n});
            dval <= (p == 1) ? 8'h30 : 8'h50;
            waitv(2, 1'b1, 100);
            waitv(0, 1'b0, 10);
            waitv(1, 1'b0, 600);
        end
        $display("test video trigger done");
        wrap_up();
    end
endmodule
